// ===== ssc_host_model.sv
// host model: drives step, direction, mode, reset, sleep and sync pins
// assumes a 25 MHz pclk; every pin change lands just after a rising edge
`timescale 1ns/1ns
module ssc_host_model
(
   input wire logic pclk, // bench clock
   output logic step_clk, // step clock pin
   output logic direction_select, // low forward
   output ssc_pkg::ssc_mode_sel_t step_mode_sel, // mode pins
   output logic logic_reset, // sequencer reset
   output logic ref_level_or_light_sleep, // light sleep
   output logic sync_chop_sel // sync request
);
   localparam int HOLD = 50; // 2 us
   initial
   begin
      step_clk = 1'b0;
      direction_select = 1'b0;
      step_mode_sel = 3'h0;
      logic_reset = 1'b0;
      ref_level_or_light_sleep = 1'b0;
      sync_chop_sel = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // direction and mode settle a full hold before the edge
   task automatic step(input logic dir, input logic [2:0] m);
      direction_select <= dir;
      step_mode_sel <= m;
      cyc(HOLD);
      step_clk <= 1'b1;
      cyc(HOLD);
      step_clk <= 1'b0;
      cyc(HOLD);
   endtask
   task automatic pins(input logic s, input logic y, input logic [2:0] m);
      ref_level_or_light_sleep <= s;
      sync_chop_sel <= y;
      step_mode_sel <= m;
      cyc(1);
   endtask
   // release waits over 5 us so no step edge meets it
   task automatic hold_reset(input logic r);
      logic_reset <= r;
      cyc(r ? HOLD : 126);
   endtask
   task automatic wake();
      cyc(2500);
   endtask
endmodule

// ===== ssc_pkg.sv
// constants, types and field layouts of the stepper sequencer control
// assumes a single 25 MHz pclk domain and an APB register port
package ssc_pkg;
   // -----------------------------------------------
   // register map
   // -----------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
   localparam int CFG_MICRO_BIT = 0;
   localparam int CFG_DUAL_BIT = 1;
   localparam logic [1:0] CFG_RST = 2'h1;
   localparam int STAT_POS_LSB = 0;
   localparam int STAT_TWO_BIT = 6;
   localparam int STAT_SLEEP_BIT = 7;
   localparam int STAT_STBY_BIT = 8;
   localparam int STAT_FLAG_BIT = 9;
   localparam int STAT_WAKE_BIT = 10;
   localparam int STAT_FAULT_LSB = 11;
   // -----------------------------------------------
   // sequencer
   // -----------------------------------------------
   localparam logic [5:0] POS_INIT = 6'h08;
   localparam logic [5:0] FULL_OFS = 6'h08;
   localparam logic [3:0] LVL_HALF = 4'h8;
   localparam logic [3:0] LVL_FULL = 4'hf;
   // -----------------------------------------------
   // timing
   // -----------------------------------------------
   localparam longint CLK_HZ = 64'd25000000;
   localparam longint WAKE_US = 64'd100;
   localparam int WAKE_CNT_W = 12;
   localparam logic [WAKE_CNT_W-1:0] WAKE_CYC =
      WAKE_CNT_W'((WAKE_US * CLK_HZ + 64'd999999) / 64'd1000000);
   // -----------------------------------------------
   // types
   // -----------------------------------------------
   typedef enum logic [2:0] {
      RES_FULL8, RES_FULLF, RES_HALF, RES_HALFF,
      RES_QUARTER, RES_EIGHTH, RES_SIXTEENTH
   } ssc_res_t;
   typedef struct packed {
      logic en;
      logic neg;
      logic [3:0] level;
   } ssc_phase_t;
   typedef struct packed {
      logic step_mode_sel_2;
      logic step_mode_sel_1;
      logic step_mode_sel_0;
   } ssc_mode_sel_t;
   typedef struct packed {
      logic coil_open;
      logic coil_short;
      logic thermal;
   } ssc_fault_t;
   typedef struct packed {
      logic step;
      logic dir;
      ssc_mode_sel_t mode;
      logic rst;
      logic sleep;
      logic sync;
      ssc_fault_t fault;
   } ssc_pins_t;
   typedef struct packed {
      ssc_pins_t s1;
      ssc_pins_t s2;
      logic step_prev;
      logic [5:0] pos;
      ssc_res_t res;
      logic flag;
      logic [1:0] cfg;
      logic [WAKE_CNT_W-1:0] wake_cnt;
      logic wake_ready;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      ssc_phase_t pa;
      ssc_phase_t pb;
      logic mon;
      logic chop;
   } ssc_state_t;
endpackage

// ===== ssc_top.sv
// stepper sequencer control: pin synchronisers, phase sequencer,
// sleep handling, protection latch and APB register slave
// assumes pins are asynchronous to pclk; fault inputs come from
// the analog protection comparators
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module ssc_top
(
   input wire logic pclk, // 25 MHz clock
   input wire logic presetn, // async reset, power cycle
   input wire logic ce, // clock enable, freezes all
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [ssc_pkg::ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic step_clk, // step clock pin
   input wire logic direction_select, // low forward
   input wire ssc_pkg::ssc_mode_sel_t step_mode_sel, // mode pins
   input wire logic logic_reset, // sequencer reset, high
   input wire logic ref_level_or_light_sleep, // high: sleep
   input wire logic sync_chop_sel, // high: sync chopping
   input wire ssc_pkg::ssc_fault_t fault_in, // protection trips
   output ssc_pkg::ssc_phase_t phase_a_drive, // phase a
   output ssc_pkg::ssc_phase_t phase_b_drive, // phase b
   output logic two_phase_monitor_out, // two-phase position
   output logic protection_flag, // protection latched
   output logic sync_chop_active // chop both phases together
);
   ssc_pkg::ssc_state_t s;
   ssc_pkg::ssc_state_t n;
   ssc_pkg::ssc_pins_t pins;
   ssc_pkg::ssc_res_t new_res;
   logic micro;
   logic dual;
   logic stby;
   logic ev;
   logic [5:0] sz;
   logic [5:0] mask;
   logic [5:0] off;
   logic [5:0] rel;
   logic on_lat;
   logic [5:0] nxt;
   logic [3:0] k;
   logic [3:0] cmag;
   logic [3:0] amag;
   logic [3:0] bmag;
   logic aneg;
   logic bneg;
   logic two_phase;
   logic [31:0] stat;
   logic setup;
   logic access;

   // -----------------------------------------------
   // pin capture
   // -----------------------------------------------
   assign pins.step = step_clk;
   assign pins.dir = direction_select;
   assign pins.mode = step_mode_sel;
   assign pins.rst = logic_reset;
   assign pins.sleep = ref_level_or_light_sleep;
   assign pins.sync = sync_chop_sel;
   assign pins.fault = fault_in;

   assign micro = s.cfg[ssc_pkg::CFG_MICRO_BIT];
   assign dual = s.cfg[ssc_pkg::CFG_DUAL_BIT];

   // -----------------------------------------------
   // mode decode
   // -----------------------------------------------
   // standby acts as a level: no step edge would ever apply it
   assign stby = s.s2.mode.step_mode_sel_2 &
      (~micro | (s.s2.mode.step_mode_sel_0 & s.s2.mode.step_mode_sel_1));

   always_comb
   begin
      case (s.s2.mode)
         3'b000: new_res = ssc_pkg::RES_FULL8;
         3'b001: new_res = ssc_pkg::RES_FULLF;
         3'b010: new_res = ssc_pkg::RES_HALF;
         3'b011: new_res = ssc_pkg::RES_HALFF;
         3'b100: new_res = ssc_pkg::RES_QUARTER;
         3'b101: new_res = ssc_pkg::RES_EIGHTH;
         3'b110: new_res = ssc_pkg::RES_SIXTEENTH;
         default: new_res = s.res;
      endcase
   end

   // -----------------------------------------------
   // step edge and next position
   // -----------------------------------------------
   // pulses shorter than one pclk period may be missed
   assign ev = ~stby & ((s.s2.step & ~s.step_prev) |
      (dual & ~s.s2.step & s.step_prev));

   always_comb
   begin
      case (new_res)
         ssc_pkg::RES_FULL8, ssc_pkg::RES_FULLF: sz = 6'h10;
         ssc_pkg::RES_HALF, ssc_pkg::RES_HALFF: sz = 6'h08;
         ssc_pkg::RES_QUARTER: sz = 6'h04;
         ssc_pkg::RES_EIGHTH: sz = 6'h02;
         ssc_pkg::RES_SIXTEENTH: sz = 6'h01;
         default: sz = 6'h10;
      endcase
   end

   assign off = (sz == 6'h10) ? ssc_pkg::FULL_OFS : 6'h00;
   assign mask = sz - 6'h01;
   assign rel = s.pos - off;
   assign on_lat = (rel & mask) == 6'h00;

   // off-lattice positions snap to the next lattice point in the
   // direction of travel, so one edge never moves more than one step
   always_comb
   begin
      if (!s.s2.dir)
      begin
         if (on_lat)
         begin
            nxt = rel + sz + off;
         end
         else
         begin
            nxt = (rel | mask) + 6'h01 + off;
         end
      end
      else
      begin
         if (on_lat)
         begin
            nxt = rel - sz + off;
         end
         else
         begin
            nxt = (rel & ~mask) + off;
         end
      end
   end

   // -----------------------------------------------
   // phase levels from position
   // -----------------------------------------------
   assign k = s.pos[3:0];
   assign cmag = (k == 4'h0) ? ssc_pkg::LVL_FULL : 4'(5'h10 - {1'b0, k});

   always_comb
   begin
      case (s.pos[5:4])
         2'h0:
         begin
            amag = cmag;
            aneg = 1'b0;
            bmag = k;
            bneg = 1'b0;
         end
         2'h1:
         begin
            amag = k;
            aneg = 1'b1;
            bmag = cmag;
            bneg = 1'b0;
         end
         2'h2:
         begin
            amag = cmag;
            aneg = 1'b1;
            bmag = k;
            bneg = 1'b1;
         end
         default:
         begin
            amag = k;
            aneg = 1'b0;
            bmag = cmag;
            bneg = 1'b1;
         end
      endcase
      if (s.res == ssc_pkg::RES_FULLF || s.res == ssc_pkg::RES_HALFF)
      begin
         if (amag != 4'h0)
         begin
            amag = ssc_pkg::LVL_FULL;
         end
         if (bmag != 4'h0)
         begin
            bmag = ssc_pkg::LVL_FULL;
         end
      end
   end

   assign two_phase =
      (amag == ssc_pkg::LVL_HALF || amag == ssc_pkg::LVL_FULL) &&
      (bmag == ssc_pkg::LVL_HALF || bmag == ssc_pkg::LVL_FULL);

   // -----------------------------------------------
   // status word and bus phases
   // -----------------------------------------------
   always_comb
   begin
      stat = 32'h0;
      stat[ssc_pkg::STAT_POS_LSB +: 6] = s.pos;
      stat[ssc_pkg::STAT_TWO_BIT] = two_phase;
      stat[ssc_pkg::STAT_SLEEP_BIT] = s.s2.sleep;
      stat[ssc_pkg::STAT_STBY_BIT] = stby;
      stat[ssc_pkg::STAT_FLAG_BIT] = s.flag;
      stat[ssc_pkg::STAT_WAKE_BIT] = s.wake_ready;
      stat[ssc_pkg::STAT_FAULT_LSB +: 3] = s.s2.fault;
   end

   assign setup = psel & ~penable;
   assign access = psel & penable & s.pready;

   // -----------------------------------------------
   // next state
   // -----------------------------------------------
   always_comb
   begin
      n = s;
      if (ce)
      begin
         n.s1 = pins;
         n.s2 = s.s1;
         n.step_prev = s.s2.step;
         if (s.s2.rst)
         begin
            // no wait for a step edge; edges during reset are dropped
            n.pos = ssc_pkg::POS_INIT;
            n.res = new_res;
         end
         else if (ev)
         begin
            n.pos = nxt;
            n.res = new_res;
         end
         n.flag = s.flag | (|s.s2.fault);
         if (s.s2.sleep || stby)
         begin
            n.wake_cnt = '0;
            n.wake_ready = 1'b0;
         end
         else if (s.wake_cnt == ssc_pkg::WAKE_CYC - 1'b1)
         begin
            n.wake_ready = 1'b1;
         end
         else
         begin
            n.wake_cnt = s.wake_cnt + 1'b1;
         end
         // reset is deliberately absent from the enable term
         n.pa.en = ~s.s2.sleep & ~stby & ~s.flag;
         n.pb.en = ~s.s2.sleep & ~stby & ~s.flag;
         n.pa.neg = aneg;
         n.pa.level = amag;
         n.pb.neg = bneg;
         n.pb.level = bmag;
         n.mon = micro & two_phase;
         n.chop = s.s2.sync & two_phase;
         n.pready = setup;
         if (setup)
         begin
            n.prdata = 32'h0;
            n.pslverr = 1'b0;
            if (paddr == ssc_pkg::CFG_OFS)
            begin
               n.prdata = {30'h0, s.cfg};
            end
            else if (paddr == ssc_pkg::STAT_OFS)
            begin
               n.prdata = stat;
            end
            else
            begin
               n.pslverr = 1'b1;
            end
         end
         if (access && pwrite && paddr == ssc_pkg::CFG_OFS)
         begin
            n.cfg = pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.pos <= ssc_pkg::POS_INIT;
         s.res <= ssc_pkg::RES_FULL8;
         s.cfg <= ssc_pkg::CFG_RST;
      end
      else
      begin
         s <= n;
      end
   end

   // -----------------------------------------------
   // outputs
   // -----------------------------------------------
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign phase_a_drive = s.pa;
   assign phase_b_drive = s.pb;
   assign two_phase_monitor_out = s.mon;
   assign protection_flag = s.flag;
   assign sync_chop_active = s.chop;

   // -----------------------------------------------
   // checks
   // -----------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence live_s;
      ce && !s.s2.rst && !stby;
   endsequence

   sequence fwd16_s;
      live_s ##0 ev && !s.s2.dir && new_res == ssc_pkg::RES_SIXTEENTH;
   endsequence

   sequence rev16_s;
      live_s ##0 ev && s.s2.dir && new_res == ssc_pkg::RES_SIXTEENTH;
   endsequence

   reset_init_a: assert property (ce && s.s2.rst |=> s.pos == 6'h08)
      else $error("sequencer not at initial position after reset");

   reset_on_a: assert property (ce && s.s2.rst && !s.s2.sleep && !stby && !s.flag
      |=> phase_a_drive.en && phase_b_drive.en)
      else $error("reset switched outputs off");

   // a mode F select shows the start position at level f, not 8
   reset_pos_a: assert property (ce && s.s2.rst ##1 ce
      |=> phase_a_drive.level == phase_b_drive.level &&
      (phase_a_drive.level == ssc_pkg::LVL_HALF || phase_a_drive.level == ssc_pkg::LVL_FULL))
      else $error("reset position not two-phase");

   step_fwd_a: assert property (fwd16_s |=> s.pos == 6'($past(s.pos) + 6'h01))
      else $error("forward step not plus one");

   step_rev_a: assert property (rev16_s |=> s.pos == 6'($past(s.pos) - 6'h01))
      else $error("reverse step not minus one");

   sleep_off_a: assert property (ce && s.s2.sleep
      |=> !phase_a_drive.en && !phase_b_drive.en)
      else $error("outputs on in light sleep");

   sleep_step_a: assert property (live_s ##0 ev && s.s2.sleep
      |=> s.pos != $past(s.pos))
      else $error("light sleep step lost");

   stby_hold_a: assert property (ce && stby |=> $stable(s.pos) && !phase_a_drive.en)
      else $error("standby moved sequencer or left outputs on");

   full8_lvl_a: assert property (ce && s.res == ssc_pkg::RES_FULL8
      && !s.s2.rst |=> phase_a_drive.level == 4'h8 && phase_b_drive.level == 4'h8)
      else $error("mode 8 full step level wrong");

   chop_pos_a: assert property (sync_chop_active |->
      (phase_a_drive.level == 4'h8 || phase_a_drive.level == 4'hf) &&
      (phase_b_drive.level == 4'h8 || phase_b_drive.level == 4'hf))
      else $error("sync chop away from two-phase position");

   flag_set_a: assert property (ce && (|s.s2.fault) |=> protection_flag)
      else $error("flag missed protection trip");

   flag_latch_a: assert property (protection_flag |=> protection_flag
      ##1 (!ce || (!phase_a_drive.en && !phase_b_drive.en)))
      else $error("protection latch released or outputs on");

endmodule

// ===== test_stepper_sequencer_control.sv
// self-checking bench of the stepper sequencer control
// assumes ssc_host_model drives the pins; apb and faults come from here
`timescale 1ns/1ns
module test_stepper_sequencer_control;
   typedef struct {int kind; logic [31:0] e; logic [31:0] m; logic err;} ssc_note_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic snap = 1'b0;
   logic ce = 1'b1;
   int awake = 0;
   localparam int WAKE_N = int'(ssc_pkg::WAKE_CYC);
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rnd = 32'hdb6a;
   logic [31:0] prdata;
   logic pready, pslverr, mon, flag_o, chop, stp, dir_p, lrst, slp_p, syn_p;
   ssc_pkg::ssc_mode_sel_t mode_p;
   ssc_pkg::ssc_fault_t fault_in = 3'h0;
   ssc_pkg::ssc_phase_t pa, pb;
   ssc_note_t notes[$];
   int fail_count = 0;
   int comparisons = 0;
   logic [5:0] pos;
   logic [14:0] pmask;
   ssc_pkg::ssc_res_t res;
   logic micro, dual, flag, two;
   logic slp = 1'b0;
   logic syn = 1'b0;
   logic stby = 1'b0;
   logic [7:0] plan [10] = '{8'h04, 8'h32, 8'h43, 8'h62, 8'h93, 8'ha2, 8'hc3, 8'h01, 8'hc1,
      8'h11};
   always #20 pclk = ~pclk;
   // cycles since the block last left reset, sleep or standby
   always @(posedge pclk)
      if (!presetn || slp || stby)
         awake <= 0;
      else if (ce)
         awake <= awake + 1;
   ssc_top u_ssc_top
   (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .step_clk(stp), .direction_select(dir_p), .step_mode_sel(mode_p),
      .logic_reset(lrst), .ref_level_or_light_sleep(slp_p), .sync_chop_sel(syn_p),
      .fault_in(fault_in), .phase_a_drive(pa), .phase_b_drive(pb),
      .two_phase_monitor_out(mon), .protection_flag(flag_o), .sync_chop_active(chop)
   );
   ssc_host_model u_ssc_host_model
   (
      .pclk(pclk), .step_clk(stp), .direction_select(dir_p), .step_mode_sel(mode_p),
      .logic_reset(lrst), .ref_level_or_light_sleep(slp_p), .sync_chop_sel(syn_p)
   );
   // ------------------------------------------------------------
   // expected behaviour
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic is_stby(input logic [2:0] m);
      return micro ? (m == 3'h7) : m[2];
   endfunction
   // neg of an unpowered phase carries no meaning, so it is masked
   function automatic logic [14:0] pin_exp();
      logic [3:0] k, c, la, lb;
      logic en;
      k = pos[3:0];
      c = (k == 4'h0) ? 4'hf : 4'h0 - k;
      {la, lb} = pos[4] ? {k, c} : {c, k};
      if (res == ssc_pkg::RES_FULLF || res == ssc_pkg::RES_HALFF)
      begin
         la = (la != 4'h0) ? 4'hf : la;
         lb = (lb != 4'h0) ? 4'hf : lb;
      end
      two = (la == 4'h8 || la == 4'hf) && (lb == 4'h8 || lb == 4'hf);
      en = !slp && !stby && !flag;
      pmask = {1'b1, la != 4'h0, 5'h1f, lb != 4'h0, 6'h3f, !flag};
      return {en, pos[5] ^ pos[4], la, en, pos[5], lb, two & micro, flag, two & syn};
   endfunction
   task automatic model_reset();
      pos = ssc_pkg::POS_INIT;
      res = ssc_pkg::RES_FULL8;
      micro = 1'b1;
      dual = 1'b0;
      flag = 1'b0;
   endtask
   task automatic mstep(input logic dir, input logic [2:0] m);
      int sz;
      int rem;
      u_ssc_host_model.step(dir, m);
      stby = is_stby(m);
      if (!stby)
      begin
         res = ssc_pkg::ssc_res_t'(m);
         sz = (m < 3'h2) ? 16 : (m < 3'h4) ? 8 : (m == 3'h4) ? 4 : (m == 3'h5) ? 2 : 1;
         repeat (dual ? 2 : 1)
         begin
            rem = int'(6'(pos - ((m < 3'h2) ? 6'h08 : 6'h00))) % sz;
            pos = dir ? pos - 6'(rem == 0 ? sz : rem) : pos + 6'(rem == 0 ? sz : sz - rem);
         end
      end
   endtask
   task automatic setp(input logic s, input logic y, input logic [2:0] m);
      u_ssc_host_model.pins(s, y, m);
      slp = s;
      syn = y;
      stby = is_stby(m);
   endtask
   // ------------------------------------------------------------
   // apb master and checks
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] m, input logic err);
      int n;
      notes.push_back('{0, e, m, err});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic check_all();
      logic [14:0] e;
      repeat (8) @(posedge pclk);
      e = pin_exp();
      notes.push_back('{1, 32'(e), 32'(pmask), 1'b0});
      snap <= 1'b1;
      @(posedge pclk);
      snap <= 1'b0;
      apb(1'b0, ssc_pkg::STAT_OFS, 32'h0, {18'h0, fault_in, awake > WAKE_N, flag, stby, slp,
         two, pos}, (awake > WAKE_N - 4 && awake < WAKE_N + 6) ? 32'hffff_fbff : 32'hffff_ffff,
         1'b0);
   endtask
   task automatic check(input string nm, input logic [32:0] e, input logic [32:0] s);
      comparisons++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp_apb(input ssc_note_t n);
      check("apb", {n.err, n.e & n.m}, {pslverr, prdata & n.m});
   endtask
   task automatic cmp_pins(input ssc_note_t n);
      check("pins", 33'(n.e[14:0] & n.m[14:0]),
         33'({pa, pb, mon, flag_o, chop} & n.m[14:0]));
   endtask
   task automatic take(input int kind);
      if (notes.size() == 0 || notes[0].kind != kind)
         check("queue", 33'(kind), 33'h1ff);
      else if (kind == 0)
         cmp_apb(notes.pop_front());
      else
         cmp_pins(notes.pop_front());
   endtask
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
         take(0);
      if (snap)
         take(1);
   end
   task automatic final_report();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (90000) @(posedge pclk);
      fail_count++;
      final_report();
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      model_reset();
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      check_all();
      apb(1'b0, ssc_pkg::CFG_OFS, 32'h0, 32'h1, 32'hffff_ffff, 1'b0);
      apb(1'b0, 8'h08, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
      apb(1'b1, 8'h0c, 32'h5, 32'h0, 32'h0, 1'b1);
      apb(1'b1, ssc_pkg::STAT_OFS, 32'h3f, 32'h0, 32'h0, 1'b0);
      foreach (plan[i])
      begin
         repeat (plan[i][3:0])
         begin
            mstep(plan[i][4], plan[i][7:5]);
            check_all();
         end
      end
      repeat (12)
      begin
         rnd = lfsr(rnd);
         setp(1'b0, rnd[3], (rnd[2:0] == 3'h7) ? 3'h0 : rnd[2:0]);
         mstep(rnd[4], (rnd[2:0] == 3'h7) ? 3'h0 : rnd[2:0]);
         check_all();
      end
      setp(1'b1, 1'b0, 3'h2);
      check_all();
      mstep(1'b0, 3'h2);
      mstep(1'b0, 3'h2);
      check_all();
      setp(1'b0, 1'b0, 3'h2);
      u_ssc_host_model.wake();
      check_all();
      setp(1'b0, 1'b0, 3'h7);
      mstep(1'b1, 3'h7);
      check_all();
      setp(1'b0, 1'b0, 3'h0);
      u_ssc_host_model.wake();
      mstep(1'b0, 3'h0);
      check_all();
      apb(1'b1, ssc_pkg::CFG_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
      micro = 1'b0;
      mstep(1'b0, 3'h4);
      check_all();
      setp(1'b0, 1'b0, 3'h0);
      u_ssc_host_model.wake();
      apb(1'b1, ssc_pkg::CFG_OFS, 32'h3, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ssc_pkg::CFG_OFS, 32'h0, 32'h3, 32'hffff_ffff, 1'b0);
      micro = 1'b1;
      dual = 1'b1;
      mstep(1'b1, 3'h6);
      check_all();
      u_ssc_host_model.hold_reset(1'b1);
      pos = ssc_pkg::POS_INIT;
      check_all();
      u_ssc_host_model.hold_reset(1'b0);
      // a trip seen only while the clock enable is low must not latch
      ce <= 1'b0;
      fault_in <= 3'h4;
      repeat (5) @(posedge pclk);
      fault_in <= 3'h0;
      repeat (5) @(posedge pclk);
      ce <= 1'b1;
      check_all();
      for (int i = 0; i < 3; i++)
      begin
         fault_in <= ssc_pkg::ssc_fault_t'(3'h1 << i);
         flag = 1'b1;
         check_all();
         fault_in <= 3'h0;
         u_ssc_host_model.hold_reset(1'b1);
         u_ssc_host_model.hold_reset(1'b0);
         check_all();
         presetn <= 1'b0;
         model_reset();
         repeat (6) @(posedge pclk);
         presetn <= 1'b1;
         check_all();
      end
      final_report();
   end
endmodule
